//--- core/timer16_counter.sv
// Purpose: 16-bit up/down timer with shared high-byte staging over an 8-bit bus
// Assumes: Bus strobes synchronous to pclk; ext_clock_in synchronous to pclk
// Notes: Top and bottom outputs track the counter value as it stands
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module timer16_counter
    import timer16_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    byte_bus_if.dev bus,
    input wire logic ext_clock_in,
    input wire logic capture_in,
    output logic top_out,
    output logic bottom_out,
    output logic irq_out
);
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [7:0] flags_q;
    logic [7:0] mask_q;
    logic [7:0] stage_q;
    logic [7:0] rdata_q;
    logic [15:0] count_value_q;
    logic [15:0] count_value_d;
    logic [15:0] capture_value_q;
    logic [15:0] compare_values_q [0:NUM_CMP-1];
    logic dir_down_q;
    logic ext_prev_q;
    logic [9:0] presc_q;
    logic top_q;
    logic bottom_q;
    logic irq_q;

    logic [3:0] wave_mode_field;
    logic [2:0] clock_source_field;
    logic [3:0] addr_off;
    logic [2:0] word_idx;
    logic is_word;
    logic is_lo;
    logic is_hi;
    logic [15:0] word_sel;
    logic timer_tick;
    logic [15:0] top_value;
    logic up_down;
    logic [1:0] ovf_kind;
    logic ovf_event;
    logic cnt_write;
    logic dir_down_d;
    logic cap_locked;

    assign clock_source_field = ctrl_b_q[CS_HI:CS_LO];
    assign wave_mode_field = {ctrl_b_q[WGM_B_HI:WGM_B_LO], ctrl_a_q[WGM_A_HI:WGM_A_LO]};

    // Byte address decode for the word registers
    assign addr_off = bus.addr - ADDR_CNT_LO;
    assign word_idx = addr_off[3:1];
    assign is_word = (bus.addr >= ADDR_CNT_LO) && (bus.addr <= ADDR_CAP_HI);
    assign is_lo = is_word && !bus.addr[0];
    assign is_hi = is_word && bus.addr[0];
    assign cnt_write = bus.wr_en && is_lo && (word_idx == IDX_CNT);

    always_comb begin
        case (word_idx)
            IDX_CNT: word_sel = count_value_q;
            IDX_CAP: word_sel = capture_value_q;
            default: word_sel = compare_values_q[2'(word_idx - IDX_CMP_A)];
        endcase
    end

    // Mode decode: top value, count sequence and overflow point
    always_comb begin
        top_value = VAL_MAX;
        up_down = 1'b0;
        ovf_kind = OVF_AT_MAX;
        case (wave_mode_field)
            4'h1: begin top_value = VAL_TOP8; up_down = 1'b1; ovf_kind = OVF_AT_BOTTOM; end
            4'h2: begin top_value = VAL_TOP9; up_down = 1'b1; ovf_kind = OVF_AT_BOTTOM; end
            4'h3: begin top_value = VAL_TOP10; up_down = 1'b1; ovf_kind = OVF_AT_BOTTOM; end
            4'h4: top_value = compare_values_q[0];
            4'h5: begin top_value = VAL_TOP8; ovf_kind = OVF_AT_TOP; end
            4'h6: begin top_value = VAL_TOP9; ovf_kind = OVF_AT_TOP; end
            4'h7: begin top_value = VAL_TOP10; ovf_kind = OVF_AT_TOP; end
            4'h8, 4'ha: begin
                top_value = capture_value_q;
                up_down = 1'b1;
                ovf_kind = OVF_AT_BOTTOM;
            end
            4'h9, 4'hb: begin
                top_value = compare_values_q[0];
                up_down = 1'b1;
                ovf_kind = OVF_AT_BOTTOM;
            end
            4'hc: top_value = capture_value_q;
            4'he: begin top_value = capture_value_q; ovf_kind = OVF_AT_TOP; end
            4'hf: begin top_value = compare_values_q[0]; ovf_kind = OVF_AT_TOP; end
            default: top_value = VAL_MAX;
        endcase
    end

    // Capture register defines top in these modes, so external captures are blocked
    assign cap_locked = (wave_mode_field == 4'h8) || (wave_mode_field == 4'ha) ||
                        (wave_mode_field == 4'hc) || (wave_mode_field == 4'he);

    // Prescaler runs only while a source is selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= 10'h000;
        end else if (clock_source_field == CS_STOP) begin
            presc_q <= 10'h000;
        end else begin
            presc_q <= presc_q + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_clock_in;
        end
    end

    always_comb begin
        case (clock_source_field)
            CS_STOP: timer_tick = 1'b0;
            CS_EXT_FALL: timer_tick = ext_prev_q && !ext_clock_in;
            CS_EXT_RISE: timer_tick = !ext_prev_q && ext_clock_in;
            default: begin
                timer_tick = (presc_q & PRESC_MASK[clock_source_field]) ==
                             PRESC_MASK[clock_source_field];
            end
        endcase
    end

    // Next count and direction
    always_comb begin
        count_value_d = count_value_q;
        dir_down_d = dir_down_q;
        ovf_event = 1'b0;
        if (timer_tick) begin
            if (!up_down) begin
                dir_down_d = 1'b0;
                count_value_d = (count_value_q == top_value) ? VAL_BOTTOM
                                                            : count_value_q + 16'h0001;
            end else if (!dir_down_q && (count_value_q >= top_value)) begin
                dir_down_d = 1'b1;
                count_value_d = count_value_q - 16'h0001;
            end else if (dir_down_q && (count_value_q == VAL_BOTTOM)) begin
                dir_down_d = 1'b0;
                count_value_d = count_value_q + 16'h0001;
            end else begin
                count_value_d = dir_down_q ? count_value_q - 16'h0001
                                           : count_value_q + 16'h0001;
            end
            case (ovf_kind)
                OVF_AT_TOP: ovf_event = (count_value_q == top_value);
                OVF_AT_BOTTOM: ovf_event = dir_down_q && (count_value_q == VAL_BOTTOM);
                default: ovf_event = (count_value_q == VAL_MAX);
            endcase
        end
        if (cnt_write) begin
            count_value_d = {stage_q, bus.wdata};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_q <= RST_WORD;
            dir_down_q <= 1'b0;
        end else begin
            count_value_q <= count_value_d;
            dir_down_q <= dir_down_d;
        end
    end

    // Staging byte: high writes land here, low reads of count and capture refill it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q <= RST_BYTE;
        end else if (bus.wr_en && is_hi) begin
            stage_q <= bus.wdata;
        end else if (bus.rd_en && is_lo && (word_idx == IDX_CNT || word_idx == IDX_CAP)) begin
            stage_q <= word_sel[15:8];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    compare_values_q[gi] <= RST_WORD;
                end else if (bus.wr_en && is_lo && (word_idx == IDX_CMP_A + 3'(gi))) begin
                    compare_values_q[gi] <= {stage_q, bus.wdata};
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value_q <= RST_WORD;
        end else if (bus.wr_en && is_lo && (word_idx == IDX_CAP)) begin
            capture_value_q <= {stage_q, bus.wdata};
        end else if (capture_in && !cap_locked) begin
            capture_value_q <= count_value_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_q <= RST_BYTE;
            ctrl_b_q <= RST_BYTE;
            mask_q <= RST_BYTE;
        end else if (bus.wr_en) begin
            if (bus.addr == ADDR_CTRL_A) ctrl_a_q <= bus.wdata;
            if (bus.addr == ADDR_CTRL_B) ctrl_b_q <= bus.wdata;
            if (bus.addr == ADDR_MASK) mask_q <= bus.wdata;
        end
    end

    // Writing one clears a flag; a same-cycle event still sets it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= RST_BYTE;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if ((i == FLAG_OVF && ovf_event) ||
                    (i == FLAG_CAP && capture_in && !cap_locked)) begin
                    flags_q[i] <= 1'b1;
                end else if (bus.wr_en && bus.addr == ADDR_FLAGS && bus.wdata[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    end

    // Read data registered: answer one cycle after the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= RST_BYTE;
        end else if (bus.rd_en) begin
            if (is_lo) begin
                rdata_q <= word_sel[7:0];
            end else if (is_hi) begin
                rdata_q <= (word_idx == IDX_CNT || word_idx == IDX_CAP) ? stage_q
                                                                     : word_sel[15:8];
            end else begin
                case (bus.addr)
                    ADDR_CTRL_A: rdata_q <= ctrl_a_q;
                    ADDR_CTRL_B: rdata_q <= ctrl_b_q;
                    ADDR_FLAGS: rdata_q <= flags_q;
                    ADDR_MASK: rdata_q <= mask_q;
                    default: rdata_q <= RST_BYTE;
                endcase
            end
        end
    end

    // Top and bottom follow the value the counter holds after this edge; irq follows flags and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_q <= 1'b0;
            bottom_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            top_q <= (count_value_d == top_value);
            bottom_q <= (count_value_d == VAL_BOTTOM);
            irq_q <= |(flags_q & mask_q);
        end
    end

    assign bus.rdata = rdata_q;
    assign top_out = top_q;
    assign bottom_out = bottom_q;
    assign irq_out = irq_q;
endmodule : timer16_counter
`default_nettype wire

//--- include/timer16_pkg.sv
// Purpose: Shared constants and types for the 16-bit timer and its byte-bus controller
// Assumes: 8-bit byte bus between the two ends, 32-bit APB on the controller
// Notes: Byte addresses of the timer are on the byte bus; APB offsets are byte addresses
package timer16_pkg;
    // Byte-bus addresses of the timer
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_FLAGS = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_CNT_LO = 4'h4;
    localparam logic [3:0] ADDR_CAP_HI = 4'hd;
    // Word index of a 16-bit register, from (address - ADDR_CNT_LO) / 2
    localparam logic [2:0] IDX_CNT = 3'h0;
    localparam logic [2:0] IDX_CMP_A = 3'h1;
    localparam logic [2:0] IDX_CAP = 3'h4;
    localparam int NUM_CMP = 3;
    // Control field positions
    localparam int WGM_A_LO = 0;
    localparam int WGM_A_HI = 1;
    localparam int CS_LO = 0;
    localparam int CS_HI = 2;
    localparam int WGM_B_LO = 3;
    localparam int WGM_B_HI = 4;
    // Flag and mask bits
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CAP = 1;
    // Counter values
    localparam logic [15:0] VAL_BOTTOM = 16'h0000;
    localparam logic [15:0] VAL_MAX = 16'hffff;
    localparam logic [15:0] VAL_TOP8 = 16'h00ff;
    localparam logic [15:0] VAL_TOP9 = 16'h01ff;
    localparam logic [15:0] VAL_TOP10 = 16'h03ff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Clock source codes and prescaler masks (tick when masked prescaler is all ones)
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PRESC_MASK [0:5] = '{10'h000, 10'h000, 10'h007,
                                               10'h03f, 10'h0ff, 10'h3ff};
    // Overflow point kinds
    localparam logic [1:0] OVF_AT_MAX = 2'h0;
    localparam logic [1:0] OVF_AT_TOP = 2'h1;
    localparam logic [1:0] OVF_AT_BOTTOM = 2'h2;
    // Controller APB map
    localparam logic [7:0] APB_DATA = 8'h00;
    localparam logic [7:0] APB_CMD = 8'h04;
    localparam logic [7:0] APB_RESULT = 8'h08;
    localparam logic [7:0] APB_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] APB_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] APB_IRQ_ENABLE = 8'h14;
    localparam int CMD_READ = 8;
    localparam int CMD_WIDE = 9;
    localparam int RESULT_BUSY = 16;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DEV = 1;
    typedef enum logic [1:0] {
        CTL_IDLE = 2'b00,
        CTL_FIRST = 2'b01,
        CTL_SECOND = 2'b10,
        CTL_LAST = 2'b11
    } ctl_state_type;
endpackage : timer16_pkg

//--- include/byte_bus_if.sv
// Purpose: 8-bit byte bus between the controller and the timer
// Assumes: One access per cycle; read data returns one cycle after the strobe
// Notes: Strobes last one cycle per byte, so a 16-bit transfer holds one high for two cycles
`timescale 1ns/1ps
`default_nettype none
interface byte_bus_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;
    modport dev (input addr, input wdata, input wr_en, input rd_en, output rdata);
    modport ctl (output addr, output wdata, output wr_en, output rd_en, input rdata);
endinterface : byte_bus_if
`default_nettype wire

//--- core/timer16_host.sv
// Purpose: APB-driven controller that performs byte and 16-bit accesses to the timer
// Assumes: Timer answers reads one cycle after the strobe
// Notes: A 16-bit transfer is one uninterrupted sequence, so staging cannot be disturbed
`timescale 1ns/1ps
`default_nettype none
module timer16_host
    import timer16_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic device_irq_in,
    byte_bus_if.ctl bus
);
    ctl_state_type state_q;
    logic [15:0] data_q;
    logic [9:0] cmd_q;
    logic [15:0] result_q;
    logic [1:0] status_q;
    logic [1:0] enable_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic dev_prev_q;
    logic [3:0] addr_q;
    logic [7:0] wdata_q;
    logic wr_q;
    logic rd_q;
    logic access;
    logic go;
    logic done;
    logic mapped;

    assign access = psel && penable && pready_q;
    assign go = access && pwrite && (paddr == APB_CMD) && (state_q == CTL_IDLE);
    assign mapped = (paddr <= APB_IRQ_ENABLE) && (paddr[1:0] == 2'b00);

    // Zero-wait slave: data registered in the setup cycle, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            case (paddr)
                APB_DATA: prdata_q <= {16'h0000, data_q};
                APB_CMD: prdata_q <= {22'h000000, cmd_q};
                APB_RESULT: prdata_q <= {15'h0000, state_q != CTL_IDLE, result_q};
                APB_IRQ_STATUS: prdata_q <= {30'h00000000, status_q};
                APB_IRQ_ENABLE: prdata_q <= {30'h00000000, enable_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= RST_WORD;
            enable_q <= 2'b00;
            cmd_q <= 10'h000;
        end else if (access && pwrite) begin
            if (paddr == APB_DATA) data_q <= pwdata[15:0];
            if (paddr == APB_IRQ_ENABLE) enable_q <= pwdata[1:0];
            if (go) cmd_q <= pwdata[9:0];
        end
    end

    // Sequencer: high before low on writes, low before high on reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CTL_IDLE;
            addr_q <= 4'h0;
            wdata_q <= RST_BYTE;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            result_q <= RST_WORD;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            case (state_q)
                CTL_IDLE: begin
                    if (go) begin
                        wr_q <= !pwdata[CMD_READ];
                        rd_q <= pwdata[CMD_READ];
                        if (pwdata[CMD_WIDE] && !pwdata[CMD_READ]) begin
                            addr_q <= pwdata[3:0] | 4'h1;
                            wdata_q <= data_q[15:8];
                        end else begin
                            addr_q <= pwdata[3:0];
                            wdata_q <= data_q[7:0];
                        end
                        state_q <= CTL_FIRST;
                    end
                end
                CTL_FIRST: begin
                    // Second byte follows at once so nothing can reuse staging between;
                    // a byte command strobes nothing here, so its read answer can arrive
                    wr_q <= cmd_q[CMD_WIDE] && !cmd_q[CMD_READ];
                    rd_q <= cmd_q[CMD_WIDE] && cmd_q[CMD_READ];
                    addr_q <= cmd_q[CMD_READ] ? (addr_q | 4'h1) : (addr_q & 4'he);
                    wdata_q <= data_q[7:0];
                    state_q <= CTL_SECOND;
                end
                CTL_SECOND: begin
                    if (cmd_q[CMD_READ]) result_q[7:0] <= bus.rdata;
                    state_q <= cmd_q[CMD_WIDE] ? CTL_LAST : CTL_IDLE;
                end
                CTL_LAST: begin
                    if (cmd_q[CMD_READ]) result_q[15:8] <= bus.rdata;
                    state_q <= CTL_IDLE;
                end
                default: state_q <= CTL_IDLE;
            endcase
        end
    end

    assign done = (state_q == CTL_LAST) || (state_q == CTL_SECOND && !cmd_q[CMD_WIDE]);

    // Sticky events; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 2'b00;
            dev_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            dev_prev_q <= device_irq_in;
            if (done) begin
                status_q[IRQ_DONE] <= 1'b1;
            end else if (access && pwrite && paddr == APB_IRQ_CLEAR && pwdata[IRQ_DONE]) begin
                status_q[IRQ_DONE] <= 1'b0;
            end
            if (device_irq_in && !dev_prev_q) begin
                status_q[IRQ_DEV] <= 1'b1;
            end else if (access && pwrite && paddr == APB_IRQ_CLEAR && pwdata[IRQ_DEV]) begin
                status_q[IRQ_DEV] <= 1'b0;
            end
            irq_q <= |(status_q & enable_q);
        end
    end

    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr_en = wr_q;
    assign bus.rd_en = rd_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
endmodule : timer16_host
`default_nettype wire

//--- sim/timer16_bus_props.sv
// Purpose: Concurrent checks on the byte bus between controller and timer
// Assumes: capture_in held low by the bench
// Notes: Count shadow is trusted only while the timer has stayed stopped
`timescale 1ns/1ps
`default_nettype none
module timer16_bus_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata
);
    logic [7:0] stg_q;
    logic [15:0] cnt_q, cmp_q;
    logic run_q, cok_q, sok_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {stg_q, cnt_q, cmp_q, run_q} <= '0;
            cok_q <= 1'b1;
            sok_q <= 1'b1;
        end else if (wr_en) begin
            if (addr inside {4'h5, 4'h7, 4'h9, 4'hb, 4'hd}) begin
                stg_q <= wdata;
                sok_q <= 1'b1;
            end
            if (addr == 4'h1) begin
                run_q <= |wdata[2:0];
                cok_q <= cok_q && wdata[2:0] == 3'h0;
            end
            if (addr == 4'h4) begin
                cnt_q <= {stg_q, wdata};
                cok_q <= !run_q;
            end
            if (addr == 4'h6) cmp_q <= {stg_q, wdata};
        end else if (rd_en && addr == 4'h4) begin
            stg_q <= cnt_q[15:8];
            sok_q <= cok_q;
        end else if (rd_en && addr == 4'hc) begin
            // Capture contents not shadowed, so staging is unknown after it
            sok_q <= 1'b0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ONE_STROBE: assert property (!(wr_en && rd_en))
        else $error("both strobes high");
    AST_RD_HOLD: assert property (!rd_en |=> $stable(rdata))
        else $error("read data moved");
    AST_UNMAPPED: assert property (rd_en && addr > 4'hd |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CMP_LO: assert property (rd_en && addr == 4'h6 |=> rdata == cmp_q[7:0])
        else $error("compare low wrong");
    AST_CMP_HI: assert property (rd_en && addr == 4'h7 |=> rdata == cmp_q[15:8])
        else $error("compare high wrong");
    AST_CNT_LO: assert property (rd_en && addr == 4'h4 && cok_q |=> rdata == cnt_q[7:0])
        else $error("count low wrong");
    AST_STG_RD: assert property (rd_en && addr inside {4'h5, 4'hd} && sok_q |=> rdata == stg_q)
        else $error("staging byte wrong");
    AST_WIDE_WR: assert property (wr_en ##1 wr_en |-> addr == $past(addr) - 4'h1)
        else $error("wide write order");
    AST_WIDE_RD: assert property (rd_en ##1 rd_en |-> addr == $past(addr) + 4'h1)
        else $error("wide read order");
    cover property (wr_en && addr == 4'h5 ##1 wr_en && addr == 4'h4);
    cover property (rd_en && addr == 4'h4 ##1 rd_en && addr == 4'h5);
    cover property (rd_en && addr == 4'h7);
endmodule : timer16_bus_props
`default_nettype wire

//--- sim/test_timer16_byte_access_counter.sv
// Purpose: Self-checking bench for the timer and its APB controller
// Assumes: capture_in held low; ext_clock_in driven by the bench
// Notes: Expected values come from the words the bench writes, the reset values and the ext pulses it drives
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_timer16_byte_access_counter
    import timer16_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic irq, dirq, top_o, bot_o, err, ext;
    logic [7:0] paddr;
    logic [3:0] ad;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] q, p, v;
    int failures = 0;
    int n_tests = 0;
    int n;
    byte_bus_if bb();
    timer16_counter timer16_counter_inst (.pclk(pclk), .presetn(presetn), .bus(bb),
        .ext_clock_in(ext), .capture_in(1'b0), .top_out(top_o), .bottom_out(bot_o),
        .irq_out(dirq));
    timer16_host timer16_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .device_irq_in(dirq), .bus(bb));
    timer16_bus_props timer16_bus_props_inst (.pclk(pclk), .presetn(presetn),
        .addr(bb.addr), .wdata(bb.wdata), .wr_en(bb.wr_en), .rd_en(bb.rd_en),
        .rdata(bb.rdata));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic end_of_test();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Idle edge first, so two back-to-back calls never assign psel twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic dev(input logic [3:0] a, input logic rd, input logic wd, input logic [15:0] d);
        apb(1'b1, APB_DATA, {16'h0000, d});
        apb(1'b1, APB_CMD, {22'h0, wd, rd, 4'h0, a});
        n = 0;
        do begin
            apb(1'b0, APB_RESULT, 32'h0);
            n++;
        end while (r[RESULT_BUSY] !== 1'b0 && n < 50);
        q = r[15:0];
        // A command that never finishes is a mismatch, not a silent pass
        if (r[RESULT_BUSY] !== 1'b0) failures++;
    endtask : dev
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ext} = '0;
        presetn = 1'b0;
        n = $urandom(91624);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        dev(4'h4, 1'b1, 1'b1, 16'h0);
        `CHK(q, RST_WORD)
        `CHK(bot_o, 1'b1)
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'h01ff : (i == 1) ? VAL_MAX : 16'($urandom);
            ad = 4'(4 + 2 * (i % 5));
            dev(ad, 1'b0, 1'b1, v);
            dev(ad, 1'b1, 1'b1, 16'h0);
            `CHK(q, v)
        end
        dev(4'h4, 1'b0, 1'b1, 16'h3c5a);
        dev(4'h5, 1'b0, 1'b0, 16'h00a5);
        dev(4'h6, 1'b0, 1'b0, 16'h0011);
        dev(4'h8, 1'b0, 1'b0, 16'h0022);
        dev(4'h6, 1'b1, 1'b1, 16'h0);
        `CHK(q, 16'ha511)
        dev(4'h8, 1'b1, 1'b1, 16'h0);
        `CHK(q, 16'ha522)
        dev(4'h5, 1'b0, 1'b0, 16'h0066);
        dev(4'h7, 1'b1, 1'b0, 16'h0);
        `CHK(q[7:0], 8'ha5)
        dev(4'h5, 1'b1, 1'b0, 16'h0);
        `CHK(q[7:0], 8'h66)
        dev(4'h4, 1'b1, 1'b1, 16'h0);
        `CHK(q, 16'h3c5a)
        dev(4'h0, 1'b0, 1'b0, 16'h0001);
        dev(4'h1, 1'b0, 1'b0, 16'h0008);
        dev(4'h4, 1'b0, 1'b1, VAL_TOP8);
        `CHK(top_o, 1'b1)
        dev(4'h0, 1'b0, 1'b0, 16'h0000);
        `CHK(top_o, 1'b0)
        dev(4'h4, 1'b0, 1'b1, 16'ha511);
        `CHK(top_o, 1'b1)
        dev(4'h1, 1'b0, 1'b0, 16'h0001);
        dev(4'h4, 1'b0, 1'b1, 16'h1234);
        dev(4'h4, 1'b1, 1'b1, 16'h0);
        `CHK(q - 16'h1235 < 16'd80, 1'b1)
        dev(4'h1, 1'b0, 1'b0, 16'h0000);
        dev(4'h4, 1'b1, 1'b1, 16'h0);
        p = q;
        dev(4'h4, 1'b1, 1'b1, 16'h0);
        `CHK(q, p)
        // External rising-edge source: five pulses give five ticks
        dev(4'h4, 1'b0, 1'b1, 16'h0000);
        dev(4'h1, 1'b0, 1'b0, 16'h0007);
        repeat (5) begin
            @(posedge pclk);
            ext <= 1'b1;
            @(posedge pclk);
            ext <= 1'b0;
        end
        dev(4'h1, 1'b0, 1'b0, 16'h0000);
        dev(4'h4, 1'b1, 1'b1, 16'h0);
        `CHK(q, 16'h0005)
        dev(4'he, 1'b1, 1'b0, 16'h0);
        `CHK(q[7:0], 8'h00)
        dev(4'h4, 1'b0, 1'b1, 16'hfff0);
        apb(1'b1, APB_IRQ_ENABLE, 32'h2);
        dev(4'h3, 1'b0, 1'b0, 16'h0001);
        `CHK(irq, 1'b0)
        dev(4'h1, 1'b0, 1'b0, 16'h0001);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        `CHK(irq, 1'b1)
        dev(4'h1, 1'b0, 1'b0, 16'h0000);
        dev(4'h2, 1'b1, 1'b0, 16'h0);
        `CHK(q[0], 1'b1)
        dev(4'h2, 1'b0, 1'b0, 16'h0001);
        dev(4'h2, 1'b1, 1'b0, 16'h0);
        `CHK(q[0], 1'b0)
        apb(1'b1, APB_IRQ_CLEAR, 32'h3);
        apb(1'b0, APB_IRQ_STATUS, 32'h0);
        `CHK(r[1:0], 2'b00)
        `CHK(irq, 1'b0)
        apb(1'b0, 8'h18, 32'h0);
        `CHK({err, r}, 33'h1_0000_0000)
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        end_of_test();
    end
endmodule : test_timer16_byte_access_counter
`default_nettype wire
